// >>> hdl/qpp_fifo.sv
// qpp_fifo: four-byte outbound fifo of one port, flip-flop storage
// assumes one clock domain and the valid/ready discipline of qpp_byte_if
`timescale 1ns/1ps
`default_nettype none
`include "qpp_cfg.svh"
module qpp_fifo (
  input wire logic clk_i,
  input wire logic resetn_i,
  qpp_byte_if.store bus
);
  logic [7:0] mem [4];
  logic [1:0] wr_idx;
  logic [1:0] rd_idx;
  logic [2:0] count;
  logic push;
  logic pop;

  // honest full and empty from the fill count
  assign bus.wr_ready = (count != `QPP_FIFO_DEPTH);
  assign bus.rd_valid = (count != 3'h0);
  assign bus.rd_data = mem[rd_idx];
  assign push = bus.wr_valid && bus.wr_ready;
  assign pop = bus.rd_valid && bus.rd_ready;

  // storage is not reset, only the pointers and the fill count
  always_ff @(posedge clk_i)
  begin
    if (push)
    begin
      mem[wr_idx] <= bus.wr_data;
    end
  end

  // pointer and count update
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      wr_idx <= 2'h0;
      rd_idx <= 2'h0;
      count <= 3'h0;
    end
    else
    begin
      wr_idx <= push ? wr_idx + 2'h1 : wr_idx;
      rd_idx <= pop ? rd_idx + 2'h1 : rd_idx;
      count <= count + {2'h0, push} - {2'h0, pop};
    end
  end
endmodule : qpp_fifo
`default_nettype wire

// >>> hdl/qpp_host_mux.sv
// qpp_host_mux: four multiplexed parallel host ports over one shared 8-bit bus
// assumes external latching transceivers per port and a register port on the system clock
// What this block does
// - four independent ports share one output bus
// - host role only, never peripheral
// - two latch clocks per port plus output enable
// - output enable admits inbound data in two-way modes
// - data byte or control byte on bus
// - direction bit copies two_way_enable_bit
// - firmware spare bit copies its control bit
// - echo mode copies echo_enable_bit
// - echo capture is inverse of strobe
// - state machine drains fifos per port mode
// - ports served round robin, latches hold values
// - per port 4-byte word register and fifo
// - distinct latch clocks select the target port
// - strobe/feed/choose/restart out, status lines in
// - signal roles follow the selected port mode
// - never two latch clocks active together
// - mode decoded from four control bits
`timescale 1ns/1ps
`default_nettype none
`include "qpp_cfg.svh"
module qpp_host_mux (
  input wire logic CLK_I,
  input wire logic RESETN_I,
  input wire logic [5:0] REG_ADDR_I,
  input wire logic [31:0] REG_WDATA_I,
  input wire logic REG_WR_I,
  input wire logic REG_RD_I,
  output logic [31:0] REG_RDATA_O,
  output logic [3:0] OUTBOUND_EMPTY_O,
  output logic [7:0] SHARED_PORT_BUS_O,
  input wire logic [7:0] SHARED_PORT_BUS_I,
  output logic SHARED_PORT_BUS_OE_N_O,
  output logic XCVR_OE_N_O,
  output logic [3:0] PORT_DATA_LATCH_CLOCK_O,
  output logic [3:0] PORT_CONTROL_LATCH_CLOCK_O,
  input wire logic [3:0] PERIPH_REPLY_N_I,
  input wire logic [3:0] PERIPH_BUSY_I,
  input wire logic [3:0] PAPER_OUT_I,
  input wire logic [3:0] PERIPH_ONLINE_I,
  input wire logic [3:0] PERIPH_ERROR_N_I
);
  localparam int STROBE_CYC = (`QPP_STROBE_NS + `QPP_CLK_NS - 1) / `QPP_CLK_NS;
  localparam logic [6:0] STROBE_LOAD = 7'(STROBE_CYC);

  // mode decode from {EPP, ECP, two_way, manual}
  function automatic qpp_pkg::qpp_mode_t mode_of(input logic [`QPP_CTRL_W-1:0] c);
    case ({c[`QPP_CTRL_EPP], c[`QPP_CTRL_ECP], c[`QPP_CTRL_TWO_WAY], c[`QPP_CTRL_MANUAL]})
      `QPP_MODE_MANUAL: mode_of = qpp_pkg::QPP_M_MANUAL;
      `QPP_MODE_AUTO: mode_of = qpp_pkg::QPP_M_AUTO;
      `QPP_MODE_BYTE: mode_of = qpp_pkg::QPP_M_BYTE;
      `QPP_MODE_ECP_FWD: mode_of = qpp_pkg::QPP_M_ECP_FWD;
      `QPP_MODE_ECP_REV: mode_of = qpp_pkg::QPP_M_ECP_REV;
      `QPP_MODE_EPP: mode_of = qpp_pkg::QPP_M_EPP;
      default: mode_of = qpp_pkg::QPP_M_UNSUPP;
    endcase
  endfunction : mode_of

  // hardware paces the strobe only in these forward modes
  function automatic logic is_auto(input qpp_pkg::qpp_mode_t m);
    is_auto = (m == qpp_pkg::QPP_M_AUTO) || (m == qpp_pkg::QPP_M_ECP_FWD);
  endfunction : is_auto

  // control-phase byte, msb first: strobe, feed, restart, choose, dir, spare, echo mode, echo capture
  function automatic logic [7:0] ctrl_byte(input logic [`QPP_CTRL_W-1:0] c, input logic strobe);
    ctrl_byte = {strobe, c[`QPP_CTRL_FEED], c[`QPP_CTRL_INIT], c[`QPP_CTRL_CHOOSE],
      c[`QPP_CTRL_TWO_WAY], c[`QPP_CTRL_SPARE], c[`QPP_CTRL_ECHO], ~strobe};
  endfunction : ctrl_byte

  // two-flop synchronisers on every pin input
  logic [27:0] sync_a;
  logic [27:0] sync_b;
  always_ff @(posedge CLK_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
    begin
      sync_a <= 28'h0000000;
      sync_b <= 28'h0000000;
    end
    else
    begin
      sync_a <= {PERIPH_ERROR_N_I, PERIPH_ONLINE_I, PAPER_OUT_I, PERIPH_BUSY_I, PERIPH_REPLY_N_I, SHARED_PORT_BUS_I};
      sync_b <= sync_a;
    end
  end

  logic [7:0] bus_in;
  logic [3:0] reply_n;
  logic [3:0] busy;
  logic [3:0] paper_out;
  logic [3:0] online;
  logic [3:0] error_n;
  assign bus_in = sync_b[7:0];
  assign reply_n = sync_b[11:8];
  assign busy = sync_b[15:12];
  assign paper_out = sync_b[19:16];
  assign online = sync_b[23:20];
  assign error_n = sync_b[27:24];

  // register port decode
  logic [1:0] reg_port;
  logic [3:0] reg_off;
  assign reg_port = REG_ADDR_I[5:4];
  assign reg_off = REG_ADDR_I[3:0];

  // per-port views used by the shared bus sequencer
  logic [3:0][`QPP_CTRL_W-1:0] ctrl_w;
  logic [3:0][7:0] cbyte;
  logic [3:0][7:0] fifo_data;
  logic [3:0][7:0] shadow;
  logic [3:0][7:0] inbound;
  logic [3:0] dirty;
  logic [3:0] data_go;
  logic [3:0] rd_go;
  logic [3:0] pop;
  logic [3:0] fifo_empty;
  logic [3:0] eng_busy;
  logic [3:0] strobe_low;
  logic [3:0] two_way_vec;
  logic [3:0] spare_vec;
  logic [3:0] echo_vec;
  logic [1:0] idx;
  qpp_pkg::qpp_bus_st_t bst;
  qpp_pkg::qpp_bus_st_t next_bst;

  for (genvar p = 0; p < 4; p++)
  begin : g_port
    qpp_byte_if bif ();
    logic [`QPP_CTRL_W-1:0] ctrl;
    logic [31:0] word;
    logic [2:0] left;
    logic [6:0] tmr;
    logic [6:0] next_tmr;
    qpp_pkg::qpp_eng_st_t eng;
    qpp_pkg::qpp_eng_st_t next_eng;
    qpp_pkg::qpp_mode_t mode;
    logic strobe;
    logic ctrl_hit;
    logic data_hit;

    qpp_fifo u_fifo (
      .clk_i(CLK_I),
      .resetn_i(RESETN_I),
      .bus(bif.store)
    );

    assign ctrl_hit = REG_WR_I && (reg_port == 2'(p)) && (reg_off == `QPP_OFF_CTRL);
    assign data_hit = REG_WR_I && (reg_port == 2'(p)) && (reg_off == `QPP_OFF_DATA);
    assign mode = mode_of(ctrl);
    // auto modes pace the strobe, the others take it straight from software
    assign strobe = is_auto(mode) ? (eng != qpp_pkg::QPP_E_STROBE) : ctrl[`QPP_CTRL_STROBE];
    assign bif.wr_valid = (left != 3'h0);
    assign bif.wr_data = word[7:0];
    assign bif.rd_ready = pop[p];
    assign ctrl_w[p] = ctrl;
    assign cbyte[p] = ctrl_byte(ctrl, strobe);
    assign dirty[p] = (cbyte[p] != shadow[p]);
    assign fifo_data[p] = bif.rd_data;
    // forward data only while the transceiver faces the cable
    assign data_go[p] = bif.rd_valid && !ctrl[`QPP_CTRL_TWO_WAY] &&
      (is_auto(mode) ? (eng == qpp_pkg::QPP_E_IDLE) : (mode == qpp_pkg::QPP_M_MANUAL));
    assign rd_go[p] = (mode == qpp_pkg::QPP_M_BYTE) || (mode == qpp_pkg::QPP_M_ECP_REV) ||
      (mode == qpp_pkg::QPP_M_EPP);
    assign fifo_empty[p] = !bif.rd_valid;
    assign eng_busy[p] = (eng != qpp_pkg::QPP_E_IDLE);
    assign strobe_low[p] = (eng == qpp_pkg::QPP_E_STROBE);
    assign two_way_vec[p] = ctrl[`QPP_CTRL_TWO_WAY];
    assign spare_vec[p] = ctrl[`QPP_CTRL_SPARE];
    assign echo_vec[p] = ctrl[`QPP_CTRL_ECHO];
    assign OUTBOUND_EMPTY_O[p] = (left == 3'h0);

    // control register; reset leaves all active-low lines inactive
    always_ff @(posedge CLK_I or negedge RESETN_I)
    begin
      if (!RESETN_I)
        ctrl <= `QPP_CTRL_RESET;
      else if (ctrl_hit)
        ctrl <= REG_WDATA_I[`QPP_CTRL_W-1:0];
    end

    // outbound word register, unloaded low byte first; a write while any byte is left is dropped
    always_ff @(posedge CLK_I or negedge RESETN_I)
    begin
      if (!RESETN_I)
      begin
        word <= 32'h00000000;
        left <= 3'h0;
      end
      else if (data_hit && (left == 3'h0))
      begin
        word <= REG_WDATA_I;
        left <= `QPP_WORD_BYTES;
      end
      else if (bif.wr_valid && bif.wr_ready)
      begin
        word <= {8'h00, word[31:8]};
        left <= left - 3'h1;
      end
    end

    // strobe pacing: setup, strobe, hold, each at least one strobe width
    always_comb
    begin
      next_eng = eng;
      next_tmr = (tmr != 7'h00) ? tmr - 7'h01 : tmr;
      case (eng)
        qpp_pkg::QPP_E_IDLE:
          if (pop[p] && is_auto(mode))
          begin
            next_eng = qpp_pkg::QPP_E_SETUP;
            next_tmr = STROBE_LOAD + `QPP_LATCH_LAG; // covers the data latch delay
          end
        qpp_pkg::QPP_E_SETUP:
          if ((tmr == 7'h00) && !busy[p])
          begin
            next_eng = qpp_pkg::QPP_E_STROBE;
            next_tmr = STROBE_LOAD;
          end
        qpp_pkg::QPP_E_STROBE:
          if (tmr == 7'h00)
          begin
            next_eng = qpp_pkg::QPP_E_HOLD;
            next_tmr = STROBE_LOAD;
          end
        qpp_pkg::QPP_E_HOLD:
          if ((tmr == 7'h00) && (ctrl[`QPP_CTRL_FAST] || !busy[p]))
            next_eng = qpp_pkg::QPP_E_IDLE;
        default:
          next_eng = qpp_pkg::QPP_E_IDLE;
      endcase
    end

    always_ff @(posedge CLK_I or negedge RESETN_I)
    begin
      if (!RESETN_I)
      begin
        eng <= qpp_pkg::QPP_E_IDLE;
        tmr <= 7'h00;
      end
      else
      begin
        eng <= next_eng;
        tmr <= next_tmr;
      end
    end
  end

  // shared bus sequencer: one visit per port, control reload before data
  logic is_ctrl;
  logic [7:0] bus_byte;
  logic [2:0] wait_cnt;
  logic [7:0] clk_vec;
  logic read_phase;
  logic any_go;
  assign any_go = dirty[idx] || data_go[idx];
  assign pop = (bst == qpp_pkg::QPP_B_PICK && !dirty[idx] && data_go[idx]) ? (4'h1 << idx) : 4'h0;
  assign read_phase = (bst == qpp_pkg::QPP_B_RD_WAIT) || (bst == qpp_pkg::QPP_B_RD_CAP);
  // limitation: one shared enable, so every two-way port's transceivers answer during any read visit
  assign XCVR_OE_N_O = !read_phase;
  assign SHARED_PORT_BUS_OE_N_O = read_phase;
  assign SHARED_PORT_BUS_O = bus_byte;
  assign PORT_DATA_LATCH_CLOCK_O = clk_vec[3:0];
  assign PORT_CONTROL_LATCH_CLOCK_O = clk_vec[7:4];

  always_comb
  begin
    next_bst = bst;
    case (bst)
      qpp_pkg::QPP_B_PICK:
        if (any_go)
          next_bst = qpp_pkg::QPP_B_SETUP;
        else if (rd_go[idx])
          next_bst = qpp_pkg::QPP_B_RD_WAIT;
      qpp_pkg::QPP_B_SETUP: next_bst = qpp_pkg::QPP_B_CLK;
      qpp_pkg::QPP_B_CLK: next_bst = qpp_pkg::QPP_B_HOLD;
      qpp_pkg::QPP_B_HOLD: next_bst = qpp_pkg::QPP_B_PICK;
      qpp_pkg::QPP_B_RD_WAIT:
        if (wait_cnt == 3'h0)
          next_bst = qpp_pkg::QPP_B_RD_CAP;
      qpp_pkg::QPP_B_RD_CAP: next_bst = qpp_pkg::QPP_B_PICK;
      default: next_bst = qpp_pkg::QPP_B_PICK;
    endcase
  end

  // state, port pointer and registered latch clocks; one-hot by construction
  always_ff @(posedge CLK_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
    begin
      bst <= qpp_pkg::QPP_B_PICK;
      idx <= 2'h0;
      clk_vec <= 8'h00;
    end
    else
    begin
      bst <= next_bst;
      idx <= (next_bst == qpp_pkg::QPP_B_PICK) ? idx + 2'h1 : idx;
      clk_vec <= (next_bst == qpp_pkg::QPP_B_CLK) ? (8'h01 << {is_ctrl, idx}) : 8'h00;
    end
  end

  // bus byte, read settle count, control shadows and inbound captures
  always_ff @(posedge CLK_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
    begin
      is_ctrl <= 1'b0;
      bus_byte <= 8'h00;
      wait_cnt <= 3'h0;
      shadow <= '0; // differs from any reset byte, so every control latch loads once
      inbound <= '0;
    end
    else
    begin
      if (bst == qpp_pkg::QPP_B_PICK && any_go)
      begin
        is_ctrl <= dirty[idx];
        bus_byte <= dirty[idx] ? cbyte[idx] : fifo_data[idx];
      end
      wait_cnt <= (bst == qpp_pkg::QPP_B_PICK) ? `QPP_RD_SETTLE : (wait_cnt - {2'h0, wait_cnt != 3'h0});
      if (bst == qpp_pkg::QPP_B_CLK && is_ctrl)
        shadow[idx] <= bus_byte;
      if (bst == qpp_pkg::QPP_B_RD_CAP)
        inbound[idx] <= bus_in;
    end
  end

  // register read, data valid only in the cycle after the strobe
  logic [31:0] rd_word;
  always_comb
  begin
    case (reg_off)
      `QPP_OFF_CTRL: rd_word = {21'h000000, ctrl_w[reg_port]};
      `QPP_OFF_STAT: rd_word = {16'h0000, inbound[reg_port], eng_busy[reg_port], fifo_empty[reg_port],
        OUTBOUND_EMPTY_O[reg_port], reply_n[reg_port], busy[reg_port], paper_out[reg_port],
        online[reg_port], error_n[reg_port]};
      default: rd_word = 32'h00000000;
    endcase
  end

  always_ff @(posedge CLK_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
      REG_RDATA_O <= 32'h00000000;
    else
      REG_RDATA_O <= REG_RD_I ? rd_word : 32'h00000000;
  end

  // checks on the shared bus and port sequencing
  logic dir_sel;
  logic spare_sel;
  logic echo_sel;
  assign dir_sel = two_way_vec[idx];
  assign spare_sel = spare_vec[idx];
  assign echo_sel = echo_vec[idx];
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RESETN_I);
  sequence s_bus_held;
    $stable(SHARED_PORT_BUS_O) && !SHARED_PORT_BUS_OE_N_O;
  endsequence
  sequence s_latch_window;
    s_bus_held ##1 s_bus_held;
  endsequence
  // popped byte reaches the bus and its port's data clock two cycles on
  sequence s_pop_latched;
    ##2 PORT_DATA_LATCH_CLOCK_O[0] && (SHARED_PORT_BUS_O == $past(fifo_data[0], 2));
  endsequence
  a_latch_one_hot: assert property ($onehot0(clk_vec))
    else $error("two latch clocks active together");
  a_latch_bus_stable: assert property ((|clk_vec) |-> s_latch_window)
    else $error("bus changed around a latch clock");
  a_echo_inverse: assert property ((|PORT_CONTROL_LATCH_CLOCK_O) |->
    (SHARED_PORT_BUS_O[0] == !SHARED_PORT_BUS_O[7]))
    else $error("echo capture not inverse of strobe");
  a_dir_copy: assert property ((|PORT_CONTROL_LATCH_CLOCK_O) |-> (SHARED_PORT_BUS_O[3] == $past(dir_sel, 2)))
    else $error("direction bit does not follow two-way bit");
  a_spare_copy: assert property ((|PORT_CONTROL_LATCH_CLOCK_O) |->
    (SHARED_PORT_BUS_O[2] == $past(spare_sel, 2)))
    else $error("spare bit does not follow control register");
  a_echo_mode_copy: assert property ((|PORT_CONTROL_LATCH_CLOCK_O) |->
    (SHARED_PORT_BUS_O[1] == $past(echo_sel, 2)))
    else $error("echo mode bit does not follow control register");
  a_ctrl_reload: assert property ($rose(dirty[0]) |-> ##[1:40] (PORT_CONTROL_LATCH_CLOCK_O[0] || !dirty[0]))
    else $error("control change not loaded into port 0 latch");
  // a read visit may only open for a port whose mode is two-way
  a_read_no_fight: assert property (!XCVR_OE_N_O |-> SHARED_PORT_BUS_OE_N_O &&
    (!$fell(XCVR_OE_N_O) || $past(rd_go[idx])))
    else $error("transceivers enabled while bus driven or port not two-way");
  a_pop_to_latch: assert property (pop[0] |-> s_pop_latched)
    else $error("popped byte not latched into port 0");
  a_strobe_width: assert property ($rose(strobe_low[0]) |-> strobe_low[0] [*8])
    else $error("paced strobe shorter than minimum");
  a_word_load: assert property ((REG_WR_I && REG_ADDR_I == {2'h0, `QPP_OFF_DATA} && OUTBOUND_EMPTY_O[0]) |=>
    !OUTBOUND_EMPTY_O[0])
    else $error("word write into empty register not taken");
endmodule : qpp_host_mux
`default_nettype wire

// >>> include/qpp_byte_if.sv
// qpp_byte_if: byte stream between an outbound word register and its port fifo
// assumes both sides run on the same clock
`timescale 1ns/1ps
`default_nettype none
interface qpp_byte_if;
  logic wr_valid;
  logic wr_ready;
  logic [7:0] wr_data;
  logic rd_valid;
  logic rd_ready;
  logic [7:0] rd_data;
  modport store (input wr_valid, input wr_data, input rd_ready, output wr_ready, output rd_valid, output rd_data);
  modport user (output wr_valid, output wr_data, output rd_ready, input wr_ready, input rd_valid, input rd_data);
endinterface : qpp_byte_if
`default_nettype wire

// >>> include/qpp_cfg.svh
// qpp_cfg.svh: offsets, field positions, reset values and timing for the quad host port mux
// assumes a 100 MHz system clock and a plain address/strobe register port
`ifndef QPP_CFG_SVH
`define QPP_CFG_SVH

// register byte offsets inside one port's 16-byte window, port number in addr[5:4]
`define QPP_OFF_CTRL 4'h0
`define QPP_OFF_DATA 4'h4
`define QPP_OFF_STAT 4'h8

// port control register fields
`define QPP_CTRL_W 11
`define QPP_CTRL_STROBE 0
`define QPP_CTRL_FEED 1
`define QPP_CTRL_INIT 2
`define QPP_CTRL_CHOOSE 3
`define QPP_CTRL_SPARE 4
`define QPP_CTRL_ECHO 5
`define QPP_CTRL_MANUAL 6
`define QPP_CTRL_TWO_WAY 7
`define QPP_CTRL_ECP 8
`define QPP_CTRL_EPP 9
`define QPP_CTRL_FAST 10
`define QPP_CTRL_RESET 11'h00f

// mode codes as {EPP, ECP, two_way, manual}
`define QPP_MODE_MANUAL 4'h1
`define QPP_MODE_AUTO 4'h0
`define QPP_MODE_BYTE 4'h3
`define QPP_MODE_ECP_FWD 4'h4
`define QPP_MODE_ECP_REV 4'h6
`define QPP_MODE_EPP 4'ha

// storage and timing
`define QPP_FIFO_DEPTH 3'h4
`define QPP_WORD_BYTES 3'h4
`define QPP_CLK_NS 10
`define QPP_STROBE_NS 500
`define QPP_LATCH_LAG 7'h03
`define QPP_RD_SETTLE 3'h4

`endif

// >>> include/qpp_pkg.sv
// qpp_pkg: types shared by the quad host port mux files
// assumes qpp_cfg.svh holds all numeric constants
package qpp_pkg;
  typedef enum logic [2:0] {QPP_M_MANUAL, QPP_M_AUTO, QPP_M_BYTE, QPP_M_ECP_FWD, QPP_M_ECP_REV, QPP_M_EPP,
    QPP_M_UNSUPP} qpp_mode_t;
  typedef enum logic [1:0] {QPP_E_IDLE, QPP_E_SETUP, QPP_E_STROBE, QPP_E_HOLD} qpp_eng_st_t;
  typedef enum logic [2:0] {QPP_B_PICK, QPP_B_SETUP, QPP_B_CLK, QPP_B_HOLD, QPP_B_RD_WAIT,
    QPP_B_RD_CAP} qpp_bus_st_t;
endpackage : qpp_pkg

// >>> verification/qpp_host_mux_tb_top.sv
// qpp_host_mux_tb_top: register-level tests of the quad host port mux
// assumes qpp_xcvr_model stands for the transceivers and printers
`timescale 1ns/1ps
`default_nettype none
module qpp_host_mux_tb_top;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [5:0] addr = 6'h00;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata;
  logic [3:0] obe, dclk, cclk, busy;
  logic [3:0] reply_n = 4'hf;
  logic [3:0] pout = 4'h0;
  logic [3:0] online = 4'h0;
  logic [3:0] err_n = 4'hf;
  logic [7:0] host, pin;
  logic [7:0] cable = 8'h3c;
  logic oe_n, xoe_n;
  int num_errors = 0;
  int compares = 0;
  localparam logic [3:0] MODES [6] = '{4'h1, 4'h0, 4'h3, 4'h4, 4'h6, 4'ha};
  localparam logic [5:0] READS = 6'h34; // read visits expected, indexed like MODES

  qpp_host_mux dut (.CLK_I(clk), .RESETN_I(rst_n), .REG_ADDR_I(addr), .REG_WDATA_I(wdata), .REG_WR_I(wr),
    .REG_RD_I(rd), .REG_RDATA_O(rdata), .OUTBOUND_EMPTY_O(obe), .SHARED_PORT_BUS_O(host),
    .SHARED_PORT_BUS_I(pin), .SHARED_PORT_BUS_OE_N_O(oe_n), .XCVR_OE_N_O(xoe_n),
    .PORT_DATA_LATCH_CLOCK_O(dclk), .PORT_CONTROL_LATCH_CLOCK_O(cclk), .PERIPH_REPLY_N_I(reply_n),
    .PERIPH_BUSY_I(busy), .PAPER_OUT_I(pout), .PERIPH_ONLINE_I(online), .PERIPH_ERROR_N_I(err_n));
  qpp_xcvr_model m (.clk_i(clk), .host_i(host), .oe_n_i(oe_n), .xoe_n_i(xoe_n), .dclk_i(dclk), .cclk_i(cclk),
    .cable_i(cable), .busy_len_i(8'h1e), .pin_o(pin), .busy_o(busy));

  initial
  begin
    forever #5 clk = ~clk;
  end

  // wide enough for the packed reset snapshot
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    compares++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic stop_test;
    if (num_errors == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : stop_test

  task automatic wr_reg(input logic [5:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask : wr_reg

  task automatic rd_reg(input logic [5:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask : rd_reg

  // control byte as the latch should see it for a control word
  function automatic logic [7:0] cbyte(input logic [10:0] w);
    return {w[0], w[1], w[2], w[3], w[7], w[4], w[5], ~w[0]};
  endfunction : cbyte

  task automatic wait_ctl(input int p, input logic [10:0] w);
    int n;
    n = 0;
    while (m.clat[p] !== cbyte(w) && n < 300)
    begin
      @(posedge clk);
      n++;
    end
    check(m.clat[p], cbyte(w));
  endtask : wait_ctl

  // shared bus may carry one latch clock at a time, only while the block drives it
  always @(posedge clk)
    if (rst_n && |{dclk, cclk})
      check({$countones({dclk, cclk}) == 1, oe_n}, 2'b10);

  // watchdog sized well above the longest test path
  initial
  begin
    repeat (20000) @(posedge clk);
    num_errors++;
    stop_test;
  end

  initial
  begin
    logic [31:0] d;
    int n, c;
    repeat (11) @(posedge clk);
    check({obe, dclk, cclk, xoe_n, oe_n, host, rdata}, {4'hf, 8'h00, 1'b1, 1'b0, 8'h00, 32'h0});
    @(posedge clk);
    rst_n <= 1'b1;
    for (int p = 0; p < 4; p++)
    begin
      rd_reg({2'(p), 4'h0}, d);
      check(d, 32'h00f);
    end
    rd_reg(6'h0c, d);
    check(d, 32'h0);
    repeat (40) @(posedge clk);
    check({m.loads[0], m.loads[1], m.loads[2], m.loads[3]}, 8'h1b);
    for (int p = 0; p < 4; p++)
      check(m.clat[p], 8'hf0);
    // auto mode on port 1; a second word written before the first has drained must be dropped
    wr_reg(6'h14, 32'h44332211);
    check(obe, 4'hd);
    wr_reg(6'h14, 32'hdeadbeef);
    n = 0;
    while (m.strobed.size() < 4 && n < 4000)
    begin
      @(posedge clk);
      n++;
    end
    repeat (300) @(posedge clk);
    check(m.strobed.size(), 4);
    check({m.strobed[0], m.strobed[1], m.strobed[2], m.strobed[3]}, 32'h11223344);
    check(obe, 4'hf);
    // manual mode on port 0, then echo path back through the loop latch
    wr_reg(6'h00, 32'h07f);
    wait_ctl(0, 11'h07f);
    wr_reg(6'h04, 32'ha5c30f5a);
    n = 0;
    while (m.dlat[0] !== 8'ha5 && n < 300)
    begin
      @(posedge clk);
      n++;
    end
    check(m.dlat[0], 8'ha5);
    wr_reg(6'h00, 32'h07e);
    wait_ctl(0, 11'h07e);
    wr_reg(6'h00, 32'h0ef);
    wait_ctl(0, 11'h0ef);
    repeat (100) @(posedge clk);
    rd_reg(6'h08, d);
    check(d[15:8], 8'ha5);
    wr_reg(6'h00, 32'h0cf);
    repeat (100) @(posedge clk);
    rd_reg(6'h08, d);
    check(d[15:8], 8'h3c);
    wr_reg(6'h00, 32'h00f);
    wait_ctl(0, 11'h00f);
    // fast timing on port 3: hold ends without waiting for busy
    wr_reg(6'h30, 32'h40f);
    wr_reg(6'h34, 32'h88776655);
    n = 0;
    while (m.strobed.size() < 9 && n < 4000)
    begin
      @(posedge clk);
      n++;
    end
    check({m.strobed[5], m.strobed[6], m.strobed[7], m.strobed[8]}, 32'h55667788);
    // every mode code on port 2: only two-way codes open the transceivers
    for (int i = 0; i < 6; i++)
    begin
      wr_reg(6'h20, {21'h0, 1'b0, MODES[i], 6'h0f});
      repeat (10) @(posedge clk); // a read visit begun under the old mode still runs out
      c = 0;
      repeat (80) @(posedge clk) c += (xoe_n === 1'b0);
      check(c != 0, READS[i]);
      rd_reg(6'h20, d);
      check(d, {21'h0, 1'b0, MODES[i], 6'h0f});
    end
    // status lines of port 3
    @(posedge clk);
    reply_n <= 4'h7;
    pout <= 4'h8;
    online <= 4'h8;
    err_n <= 4'h7;
    repeat (5) @(posedge clk);
    rd_reg(6'h38, d);
    check(d[4:0], 5'h06);
    stop_test;
  end
endmodule : qpp_host_mux_tb_top
`default_nettype wire

// >>> verification/qpp_xcvr_model.sv
// qpp_xcvr_model: external latching transceivers and printers behind the four ports
// assumes latch clocks are one-cycle pulses of the host clock and one two-way port at a time
`timescale 1ns/1ps
`default_nettype none
module qpp_xcvr_model (
  input wire logic clk_i,
  input wire logic [7:0] host_i,
  input wire logic oe_n_i,
  input wire logic xoe_n_i,
  input wire logic [3:0] dclk_i,
  input wire logic [3:0] cclk_i,
  input wire logic [7:0] cable_i,
  input wire logic [7:0] busy_len_i,
  output logic [7:0] pin_o,
  output logic [3:0] busy_o
);
  logic [7:0] last = 8'h00;
  logic [7:0] inb;
  logic [7:0] dlat [4];
  logic [7:0] clat [4];
  logic [7:0] loop_lat [4];
  int cnt [4] = '{default: 0};
  logic [7:0] strobed [$];
  logic [1:0] loads [$];
  // inbound source: gating picks the port in two-way mode, echo selects the loop latch
  always_comb
  begin
    inb = cable_i;
    for (int i = 0; i < 4; i++)
      if (clat[i][3] === 1'b1)
        inb = (clat[i][1] === 1'b1) ? loop_lat[i] : cable_i;
    if (!oe_n_i)
      pin_o = host_i;
    else if (!xoe_n_i)
      pin_o = inb;
    else
      pin_o = ~last; // released bus never shows a stale byte
    for (int i = 0; i < 4; i++)
      busy_o[i] = cnt[i] != 0;
  end
  // three 8-bit latches per port (data, control, loop), printer busy after each strobe
  always @(posedge clk_i)
  begin
    last <= pin_o;
    for (int i = 0; i < 4; i++)
    begin
      if (dclk_i[i])
        dlat[i] <= pin_o;
      if (cclk_i[i])
      begin
        clat[i] <= pin_o;
        loads.push_back(2'(i));
        if (clat[i][7] === 1'b1 && pin_o[7] === 1'b0)
        begin
          strobed.push_back(dlat[i]);
          cnt[i] <= busy_len_i;
        end
        if (clat[i][0] === 1'b0 && pin_o[0] === 1'b1)
          loop_lat[i] <= dlat[i];
      end
      else if (cnt[i] > 0)
        cnt[i] <= cnt[i] - 1;
    end
  end
endmodule : qpp_xcvr_model
`default_nettype wire
